// ===== inc/chgst_defines.vh
`ifndef CHGST_DEFINES_VH
`define CHGST_DEFINES_VH
// ****************************************
// Register offsets
// ****************************************
`define CHGST_ADDR_STATUS_MAIN 8'h08
`define CHGST_ADDR_FAULT 8'h09
`define CHGST_ADDR_REGSTAT 8'h0A
`define CHGST_ADDR_PARTINFO 8'h0B
// ****************************************
// Field positions and codes
// ****************************************
`define CHGST_BIT_MASK_VREG 1
`define CHGST_BIT_MASK_IREG 0
`define CHGST_BIT_REG_RST 7
`define CHGST_SRC_NONE 3'h0
`define CHGST_SRC_USB 3'h1
`define CHGST_SRC_ADAPTER 3'h3
`define CHGST_PHASE_IDLE 2'h0
`define CHGST_PHASE_PRE 2'h1
`define CHGST_PHASE_FAST 2'h2
`define CHGST_PHASE_DONE 2'h3
`define CHGST_NTC_NORMAL 3'h0
`define CHGST_NTC_WARM 3'h2
`define CHGST_NTC_COOL 3'h3
`define CHGST_NTC_COLD 3'h5
`define CHGST_NTC_HOT 3'h6
// ****************************************
// Reset values
// ****************************************
`define CHGST_MASK_RST 2'h0
`define CHGST_WDOG_POR 1'h1
`define CHGST_PART_RSVD 3'h4
`define CHGST_ZERO8 8'h00
`define CHGST_INIT_CNT_RST 2'h0
// ****************************************
// Packing and timing counts
// ****************************************
`define CHGST_SYNC_PAD 4'h0
`define CHGST_SYNC_LAT 2'h2
`endif

// ===== rtl/chgst_sync.v
`timescale 1ns/1ps
// ****************************************
// Two-flop synchroniser bank
// ****************************************
module chgst_sync #(
  parameter W = 8
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Data
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_q;

  // First stage read only by the second
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // chgst_sync

// ===== rtl/chgst_regs.v
`timescale 1ns/1ps
`include "chgst_defines.vh"
// Function
// - Input source reported as 3-bit code: none, USB host, adapter.
// - Charge phase 2-bit code: idle, precharge, fast, terminated.
// - Status bit 2 shows power good where the package supports it.
// - Status bit 1 high while in thermal regulation.
// - Status bit 0 high while regulating system rail at minimum.
// - Fault bit 7 set after watchdog expiry, clear in host mode, POR one.
// - Charge fault 2-bit code: normal, input, thermal shutdown, timer.
// - Thermistor condition 3-bit code: normal, warm, cool, cold, hot.
// - Second-status bit 7 shows input passed poor-source qualification.
// - Second-status bit 3 high while top-off timer counts.
// - Mask bit 1 gates interrupt pulse on entering input-voltage regulation.
// - Mask bit 0 gates interrupt pulse on entering input-current regulation.
// - Writing register-reset bit restores defaults, restarts timer, self-clears.
module chgst_regs #(
  parameter HAS_PG = 1,          // Package variant with power-good reporting
  parameter [3:0] PART_ID = 4'h5 // Arbitrary part number value
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Register port from the serial management engine
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Charger conditions from analog and charge logic
  input wire [2:0] input_source_type_i,
  input wire [1:0] charge_phase_i,
  input wire power_good_flag_i,
  input wire thermal_regulation_flag_i,
  input wire min_system_regulation_flag_i,
  input wire watchdog_expired_i,
  input wire [1:0] charge_fault_code_i,
  input wire battery_overvoltage_flag_i,
  input wire [2:0] thermistor_condition_code_i,
  input wire input_source_qualified_i,
  input wire input_voltage_reg_flag_i,
  input wire input_current_reg_flag_i,
  input wire topoff_timer_running_i,
  input wire input_overvoltage_flag_i,
  // Outputs to the rest of the device
  output reg irq_pulse_o,
  output reg reg_reset_o,
  output reg safety_timer_restart_o
);
  // ****************************************
  // Helper functions
  // ****************************************
  // Write strobe aimed at one register offset; used by every writable field
  function chgst_wr_hit;
    input wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      chgst_wr_hit = wr && (addr == target);
    end
  endfunction

  // Entry into a regulation loop, unless its mask blocks the pulse
  function chgst_irq_edge;
    input now;
    input prev;
    input mask;
    begin
      chgst_irq_edge = now && !prev && !mask;
    end
  endfunction

  // ****************************************
  // Synchronised condition inputs
  // ****************************************
  wire [23:0] raw_w;
  wire [23:0] sync_w;
  // Twenty condition bits packed from the top; the spare low bits are
  // zero fill so the vector matches the synchroniser width exactly
  assign raw_w = {input_source_type_i, charge_phase_i, power_good_flag_i,
                  thermal_regulation_flag_i, min_system_regulation_flag_i,
                  watchdog_expired_i, charge_fault_code_i,
                  battery_overvoltage_flag_i, thermistor_condition_code_i,
                  input_source_qualified_i, input_voltage_reg_flag_i,
                  input_current_reg_flag_i, topoff_timer_running_i,
                  input_overvoltage_flag_i, `CHGST_SYNC_PAD};

  // Analog flags arrive asynchronously, so every one passes two flops
  chgst_sync #(.W(24)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(raw_w),
    .q_o(sync_w)
  );

  wire [2:0] src_w = sync_w[23:21];
  wire [1:0] phase_w = sync_w[20:19];
  wire pg_w = sync_w[18];
  wire therm_w = sync_w[17];
  wire vsys_w = sync_w[16];
  wire wdog_w = sync_w[15];
  wire [1:0] cfault_w = sync_w[14:13];
  wire batov_w = sync_w[12];
  wire [2:0] ntc_w = sync_w[11:9];
  wire qual_w = sync_w[8];
  wire vreg_w = sync_w[7];
  wire ireg_w = sync_w[6];
  wire topoff_w = sync_w[5];
  wire acov_w = sync_w[4];

  // ****************************************
  // Writable state
  // ****************************************
  reg [1:0] mask_q;
  reg wdog_q;
  reg vreg_prev_q;
  reg ireg_prev_q;
  reg [1:0] init_cnt_q;
  wire rst_cmd_w;

  // Only the two mask bits and the reset command bit accept writes
  assign rst_cmd_w = chgst_wr_hit(reg_wr_i, reg_addr_i, `CHGST_ADDR_PARTINFO)
                     && reg_wdata_i[`CHGST_BIT_REG_RST];

  // Masks; register reset returns them to default
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      mask_q <= `CHGST_MASK_RST;
    end else if (rst_cmd_w) begin
      mask_q <= `CHGST_MASK_RST;
    end else if (chgst_wr_hit(reg_wr_i, reg_addr_i, `CHGST_ADDR_REGSTAT)) begin
      // Upper bits of the write are dropped, the status there stays live
      mask_q <= reg_wdata_i[`CHGST_BIT_MASK_VREG:`CHGST_BIT_MASK_IREG];
    end
  end

  // Command pulses; the reset bit never stores, so it reads back zero
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_reset_o <= 1'b0;
      safety_timer_restart_o <= 1'b0;
    end else begin
      reg_reset_o <= rst_cmd_w;
      safety_timer_restart_o <= rst_cmd_w;
    end
  end

  // Watchdog flag: one from power-on until the synchroniser holds a real
  // sample; following it any earlier would show the flops' reset zero for
  // a cycle and make a fresh part look as if it were under host control
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wdog_q <= `CHGST_WDOG_POR;
      init_cnt_q <= `CHGST_INIT_CNT_RST;
    end else if (init_cnt_q != `CHGST_SYNC_LAT) begin
      init_cnt_q <= init_cnt_q + 2'h1;
    end else begin
      wdog_q <= wdog_w;
    end
  end

  // ****************************************
  // Interrupt pulses
  // ****************************************
  // Edge detectors start from zero, the idle level of both loop flags,
  // so leaving reset with a loop inactive raises no false pulse
  wire vreg_rise_w;
  wire ireg_rise_w;
  assign vreg_rise_w = chgst_irq_edge(vreg_w, vreg_prev_q,
                                      mask_q[`CHGST_BIT_MASK_VREG]);
  assign ireg_rise_w = chgst_irq_edge(ireg_w, ireg_prev_q,
                                      mask_q[`CHGST_BIT_MASK_IREG]);

  // Voltage loop pulses on entry; current loop pulses on entry too,
  // since a level during the whole loop would not be a pulse
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      vreg_prev_q <= 1'b0;
      ireg_prev_q <= 1'b0;
      irq_pulse_o <= 1'b0;
    end else begin
      vreg_prev_q <= vreg_w;
      ireg_prev_q <= ireg_w;
      irq_pulse_o <= vreg_rise_w || ireg_rise_w;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  reg [7:0] rdata_d;

  // Live composition of each register on every read; status lags the
  // pins by the two synchroniser cycles, so a code is never half settled
  always @* begin
    rdata_d = `CHGST_ZERO8;
    case (reg_addr_i)
      `CHGST_ADDR_STATUS_MAIN: begin
        rdata_d = {src_w, phase_w,
                   (HAS_PG != 0) ? pg_w : 1'b0,
                   therm_w, vsys_w};
      end
      `CHGST_ADDR_FAULT: begin
        rdata_d = {wdog_q, 1'b0, cfault_w, batov_w, ntc_w};
      end
      `CHGST_ADDR_REGSTAT: begin
        rdata_d = {qual_w, vreg_w, ireg_w, 1'b0, topoff_w, acov_w,
                   mask_q};
      end
      `CHGST_ADDR_PARTINFO: begin
        rdata_d = {1'b0, PART_ID, `CHGST_PART_RSVD};
      end
      default: begin
        rdata_d = `CHGST_ZERO8;
      end
    endcase
  end

  // Read data held in a flop; updated only on a read strobe
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= `CHGST_ZERO8;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_d;
    end
  end
endmodule // chgst_regs

// ===== bench/chgst_regs_sva.sv
`timescale 1ns/1ps
// ****************************************
// Register bank checker
// ****************************************
module chgst_regs_sva #(parameter [3:0] PART_ID = 4'h5) (
  // Clock, reset, register port and outputs
  input wire clk_i, rst_n_i, reg_wr_i, reg_rd_i, irq_pulse_o, reg_reset_o, safety_timer_restart_o,
  input wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
  // Conditions
  input wire [2:0] input_source_type_i, thermistor_condition_code_i,
  input wire [1:0] charge_phase_i, charge_fault_code_i,
  input wire power_good_flag_i, thermal_regulation_flag_i, min_system_regulation_flag_i,
  input wire watchdog_expired_i, battery_overvoltage_flag_i, input_source_qualified_i,
  input wire input_voltage_reg_flag_i, input_current_reg_flag_i, topoff_timer_running_i,
  input wire input_overvoltage_flag_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [19:0] c = {input_source_type_i, charge_phase_i, power_good_flag_i,
    thermal_regulation_flag_i, min_system_regulation_flag_i, watchdog_expired_i,
    charge_fault_code_i, battery_overvoltage_flag_i, thermistor_condition_code_i,
    input_source_qualified_i, input_voltage_reg_flag_i, input_current_reg_flag_i,
    topoff_timer_running_i, input_overvoltage_flag_i};
  wire rc = reg_wr_i && reg_addr_i == 8'h0B && reg_wdata_i[7];
  reg [1:0] m_q;
  // Mirror of the mask bits, so the interrupt checks know the gate
  always @(posedge clk_i)
    if (!rst_n_i || rc) m_q <= 2'h0;
    else if (reg_wr_i && reg_addr_i == 8'h0A) m_q <= reg_wdata_i[1:0];
  // Inputs held long enough to cross the two sync flops, then a read well clear of reset
  sequence s_rd(ad); $stable(c)[*3] ##0 reg_rd_i && reg_addr_i == ad && $past(rst_n_i, 3); endsequence
  sequence s_vup; $rose(input_voltage_reg_flag_i) && !m_q[1] ##1 input_voltage_reg_flag_i[*2]; endsequence
  sequence s_iup; $rose(input_current_reg_flag_i) && !m_q[0] ##1 input_current_reg_flag_i[*2]; endsequence
  property p_main; s_rd(8'h08) |=> reg_rdata_o == c[19:12]; endproperty
  property p_fault; s_rd(8'h09) |=> reg_rdata_o == {c[11], 1'h0, c[10:5]}; endproperty
  property p_regst; s_rd(8'h0A) |=> reg_rdata_o == {c[4:2], 1'h0, c[1:0], m_q}; endproperty
  property p_part; reg_rd_i && reg_addr_i == 8'h0B |=> reg_rdata_o == {1'h0, PART_ID, 3'h4}; endproperty
  property p_unmap;
    reg_rd_i && (reg_addr_i < 8'h08 || reg_addr_i > 8'h0B) |=> reg_rdata_o == 8'h00;
  endproperty
  property p_rst; rc |=> reg_reset_o && safety_timer_restart_o ##1 !reg_reset_o; endproperty
  property p_virq; s_vup |-> ##[0:2] irq_pulse_o; endproperty
  property p_iirq; s_iup |-> ##[0:2] irq_pulse_o; endproperty
  property p_mask; (m_q == 2'h3)[*5] |-> !irq_pulse_o; endproperty
  property p_wdog; reg_rd_i && reg_addr_i == 8'h09 && !$past(rst_n_i, 2) |=> reg_rdata_o[7]; endproperty
  a_main: assert property (p_main) else $error("status read wrong");
  a_fault: assert property (p_fault) else $error("fault read wrong");
  a_regst: assert property (p_regst) else $error("second status wrong");
  a_part: assert property (p_part) else $error("part info wrong");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_rst: assert property (p_rst) else $error("reset pulse wrong");
  a_virq: assert property (p_virq) else $error("voltage irq missing");
  a_iirq: assert property (p_iirq) else $error("current irq missing");
  a_mask: assert property (p_mask) else $error("masked irq seen");
  a_wdog: assert property (p_wdog) else $error("watchdog power-on value wrong");
endmodule // chgst_regs_sva
bind chgst_regs chgst_regs_sva #(.PART_ID(PART_ID)) u_sva (.*);

// ===== bench/chgst_host.sv
`timescale 1ns/1ps
// ****************************************
// Host side of the register port
// ****************************************
module chgst_host (
  input wire clk_i,
  input wire [7:0] rdata_i,
  output reg [7:0] addr_o = 8'hFF,
  output reg [7:0] wdata_o = 8'hFF,
  output reg wr_o = 1'h0,
  output reg rd_o = 1'h0
);
  // Masks and the reset command are written here
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'h1;
    @(posedge clk_i);
    wr_o <= 1'h0;
    addr_o <= ~a; // Released bus must not keep the old value
    wdata_o <= ~d;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'h1;
    @(posedge clk_i);
    rd_o <= 1'h0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule // chgst_host

// ===== bench/testbench.sv
`timescale 1ns/1ps
`define CK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
  reg clk_i = 1'h0;
  reg rst_n_i = 1'h0;
  reg [19:0] c = 20'h0;
  reg [7:0] d;
  wire [7:0] a, wd, rdat;
  wire w, r, irq, rr, st;
  integer n_mismatch = 0, checked = 0, np = 0, n0;
  always #25 clk_i = ~clk_i;
  // Pulses are counted here, as they stand for one cycle only
  always @(posedge clk_i) np <= np + (irq === 1'h1);
  chgst_host host (.clk_i(clk_i), .rdata_i(rdat), .addr_o(a), .wdata_o(wd), .wr_o(w), .rd_o(r));
  chgst_regs uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(a), .reg_wr_i(w),
    .reg_wdata_i(wd), .reg_rd_i(r), .reg_rdata_o(rdat), .input_source_type_i(c[19:17]),
    .charge_phase_i(c[16:15]), .power_good_flag_i(c[14]), .thermal_regulation_flag_i(c[13]),
    .min_system_regulation_flag_i(c[12]), .watchdog_expired_i(c[11]),
    .charge_fault_code_i(c[10:9]), .battery_overvoltage_flag_i(c[8]),
    .thermistor_condition_code_i(c[7:5]), .input_source_qualified_i(c[4]),
    .input_voltage_reg_flag_i(c[3]), .input_current_reg_flag_i(c[2]),
    .topoff_timer_running_i(c[1]), .input_overvoltage_flag_i(c[0]), .irq_pulse_o(irq),
    .reg_reset_o(rr), .safety_timer_restart_o(st));
  // Every source, phase, fault and thermistor code, flags toggled
  task t_status;
    integer k;
    reg [99:0] t;
    t = 100'h600C0_3FEBF_72561_2DA52_00000;
    for (k = 0; k < 5; k++) begin
      @(posedge clk_i) c <= t[k*20 +: 20];
      repeat (4) @(posedge clk_i);
      host.rd(8'h08, d); `CK(d, c[19:12])
      host.rd(8'h09, d); `CK(d, {c[11], 1'h0, c[10:5]})
      host.rd(8'h0A, d); `CK(d, {c[4:2], 1'h0, c[1:0], 2'h0})
    end
  endtask
  // Writes to read-only places leave them live
  task t_ro;
    host.wr(8'h08, 8'hFF);
    host.wr(8'h0B, 8'h7F);
    host.wr(8'h0A, 8'hFF);
    host.rd(8'h08, d); `CK(d, c[19:12])
    host.rd(8'h0B, d); `CK(d, 8'h2C)
    host.rd(8'h0A, d); `CK(d, {c[4:2], 1'h0, c[1:0], 2'h3})
    host.rd(8'h0C, d); `CK(d, 8'h00)
  endtask
  task pulse(input integer i, input integer e);
    n0 = np;
    @(posedge clk_i) c[i] <= 1'h1;
    repeat (8) @(posedge clk_i);
    `CK(np - n0, e)
    c[i] <= 1'h0;
    repeat (4) @(posedge clk_i);
  endtask
  task t_irq;
    pulse(3, 0);
    host.wr(8'h0A, 8'h01);
    pulse(3, 1);
    pulse(2, 0);
    host.wr(8'h0A, 8'h02);
    pulse(2, 1);
    pulse(3, 0);
  endtask
  // Register reset clears masks and pulses once; a zero write does nothing
  task t_rst;
    host.wr(8'h0A, 8'h03);
    pulse(2, 0);
    host.wr(8'h0B, 8'h80);
    #1 `CK({rr, st}, 2'h3)
    @(posedge clk_i) #1 `CK({rr, st}, 2'h0)
    host.rd(8'h0B, d); `CK(d, 8'h2C)
    host.rd(8'h0A, d); `CK(d[1:0], 2'h0)
    host.wr(8'h0A, 8'h03);
    host.wr(8'h0B, 8'h00);
    #1 `CK({rr, st}, 2'h0)
    host.rd(8'h0A, d); `CK(d[1:0], 2'h3)
  endtask
  task report_and_stop;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Whole run takes about 10 us; the limit leaves ample margin
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'h1;
    host.rd(8'h09, d); `CK(d[7], 1'h1)
    t_status;
    t_ro;
    t_irq;
    t_rst;
    report_and_stop;
  end
endmodule // testbench
